/* File: include/status_pkg.sv */
// constants, types and register map of the status and light block
package status_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned BLINK_HALF_MS  = 500;
   localparam int unsigned BLINK_HALF_CYC =
      (BLINK_HALF_MS * 1_000_000) / CLK_PERIOD_NS;
   localparam int unsigned PWM_STEP_NS    = 10_000;
   localparam int unsigned PWM_STEP_CYC   =
      (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  BRIGHT_STEPS   = 4'ha;

   // ---------------------------------------------------------------
   // register addresses (holding and input spaces)
   // ---------------------------------------------------------------
   localparam logic [15:0] ADDR_BUS_TERM     = 16'h0009;
   localparam logic [15:0] ADDR_ACTIVE_THR   = 16'h0023;
   localparam logic [15:0] ADDR_STANDBY_THR  = 16'h0024;
   localparam logic [15:0] ADDR_LIGHT_LUX    = 16'h0029;
   localparam logic [15:0] ADDR_LIGHT_CLASS  = 16'h002a;
   localparam logic [15:0] ADDR_SRC_SELECT   = 16'h004f;
   localparam logic [15:0] ADDR_GREEN_BRIGHT = 16'h0050;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int unsigned TERM_EN_BIT = 0;
   localparam int unsigned SRC_SEL_BIT = 0;

   localparam logic [15:0] RST_BUS_TERM     = 16'h0000;
   localparam logic [15:0] RST_ACTIVE_THR   = 16'h01f4;
   localparam logic [15:0] RST_STANDBY_THR  = 16'h0064;
   localparam logic [15:0] RST_SRC_SELECT   = 16'h0000;
   localparam logic [15:0] RST_GREEN_BRIGHT = 16'h000a;

   // ---------------------------------------------------------------
   // light class codes
   // ---------------------------------------------------------------
   localparam logic [15:0] CLASS_STANDBY = 16'h0000;
   localparam logic [15:0] CLASS_LOW     = 16'h0001;
   localparam logic [15:0] CLASS_ACTIVE  = 16'h0002;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      LED_OFF,
      LED_GREEN,
      LED_YELLOW,
      LED_RED,
      LED_RED_BLINK
   } led_e;

   typedef struct packed {
      logic signed [15:0] meas_min;
      logic signed [15:0] alert_min;
      logic signed [15:0] alert_max;
      logic signed [15:0] meas_max;
   } range_s;

   typedef struct packed {
      logic signed [15:0] temp;
      logic signed [15:0] hum;
      logic        [15:0] lux;
      logic               link_ok;
   } meas_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        input_space;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [15:0] rdata;
   } reg_rsp_s;

endpackage

/* File: hw/indicator_pwm.sv */
// brightness modulator for one indicator, ten duty steps
`timescale 1ns/100ps
module indicator_pwm
   import status_pkg::*;
(
   input  wire logic       clk_i,     // system clock
   input  wire logic       rst_n_i,   // async reset, active low
   input  wire logic       enable_i,  // indicator selected
   input  wire logic [3:0] duty_i,    // on slots out of ten
   output logic            pwm_o      // registered drive
);

   typedef struct packed {
      logic [9:0] step_cnt;
      logic [3:0] slot;
      logic       out;
   } pwm_state_s;

   pwm_state_s state_ff;
   pwm_state_s nxt_state;

   always_comb begin
      nxt_state = state_ff;
      if (state_ff.step_cnt == 10'(PWM_STEP_CYC - 1)) begin
         nxt_state.step_cnt = 10'h000;
         if (state_ff.slot == BRIGHT_STEPS - 4'h1) begin
            nxt_state.slot = 4'h0;
         end else begin
            nxt_state.slot = state_ff.slot + 4'h1;
         end
      end else begin
         nxt_state.step_cnt = state_ff.step_cnt + 10'h001;
      end
      nxt_state.out = enable_i && (state_ff.slot < duty_i);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign pwm_o = state_ff.out;

endmodule // indicator_pwm

/* File: hw/status_led_and_light_classifier.sv */
// status indicators, light classifier and register file of the sensor
`timescale 1ns/100ps
module status_led_and_light_classifier
   import status_pkg::*;
#(
   parameter int unsigned BLINK_HALF_CYCLES = status_pkg::BLINK_HALF_CYC
)
(
   input  wire logic               SYS_CLK_I,     // 100 MHz clock
   input  wire logic               RESET_N_I,     // async reset, low
   input  wire status_pkg::meas_s  MEAS_I,        // front-end results
   input  wire status_pkg::range_s TEMP_RANGE_I,  // temperature bounds
   input  wire status_pkg::range_s HUM_RANGE_I,   // humidity bounds
   input  wire status_pkg::reg_req_s REG_REQ_I,   // register request
   output status_pkg::reg_rsp_s    REG_RSP_O,     // register answer
   output logic                    LED_GREEN_O,   // green drive
   output logic                    LED_YELLOW_O,  // yellow drive
   output logic                    LED_RED_O,     // red drive
   output logic                    BUS_TERM_EN_O  // bus_terminator on
);

   import status_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] bus_term;
      logic [15:0] active_thr;
      logic [15:0] standby_thr;
      logic [15:0] src_select;
      logic [15:0] green_bright;
      logic [15:0] light_lux;
      logic [15:0] light_class;
      led_e        status;
      logic [25:0] blink_cnt;
      logic        blink;
      logic        red;
      logic        yellow;
      logic        green_on;
      logic [3:0]  green_duty;
      reg_rsp_s    rsp;
      logic        term_out;
   } top_state_s;

   top_state_s state_ff;
   top_state_s nxt_state;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic led_e classify(input logic signed [15:0] v,
                                     input range_s r);
      led_e res;
      res = LED_GREEN;
      if (v < r.meas_min || v > r.meas_max) begin
         res = LED_RED;
      end else if (v < r.alert_min || v > r.alert_max) begin
         res = LED_YELLOW;
      end
      return res;
   endfunction

   function automatic logic [15:0] light_code(input logic [15:0] lux,
                                              input logic [15:0] stb,
                                              input logic [15:0] act);
      logic [15:0] res;
      res = CLASS_LOW;
      if (lux < stb) begin
         res = CLASS_STANDBY;
      end else if (lux > act) begin
         res = CLASS_ACTIVE;
      end
      return res;
   endfunction

   function automatic logic [3:0] clamp_duty(input logic [15:0] v);
      logic [3:0] res;
      res = BRIGHT_STEPS;
      if (v < {12'h000, BRIGHT_STEPS}) begin
         res = v[3:0];
      end
      return res;
   endfunction

   function automatic logic holding_addr_ok(input logic [15:0] a);
      return (a == ADDR_BUS_TERM)    || (a == ADDR_ACTIVE_THR) ||
             (a == ADDR_STANDBY_THR) || (a == ADDR_SRC_SELECT) ||
             (a == ADDR_GREEN_BRIGHT);
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic signed [15:0] sel_value;
   range_s             sel_range;
   led_e               cur_status;
   logic [15:0]        rd_value;
   logic               rd_hit;

   always_comb begin
      nxt_state  = state_ff;
      sel_value  = MEAS_I.temp;
      sel_range  = TEMP_RANGE_I;
      cur_status = LED_OFF;
      rd_value   = 16'h0000;
      rd_hit     = 1'b0;

      // ------------------------------------------------------------
      // indicator source
      // ------------------------------------------------------------
      if (state_ff.src_select[SRC_SEL_BIT]) begin
         sel_value = MEAS_I.hum;
         sel_range = HUM_RANGE_I;
      end

      // ------------------------------------------------------------
      // status selection
      // ------------------------------------------------------------
      if (!MEAS_I.link_ok) begin
         cur_status = LED_RED_BLINK;
      end else begin
         cur_status = classify(sel_value, sel_range);
      end
      nxt_state.status = cur_status;

      // ------------------------------------------------------------
      // blink timebase
      // ------------------------------------------------------------
      if (state_ff.blink_cnt == 26'(BLINK_HALF_CYCLES - 1)) begin
         nxt_state.blink_cnt = 26'h0000000;
         nxt_state.blink     = !state_ff.blink;
      end else begin
         nxt_state.blink_cnt = state_ff.blink_cnt + 26'h0000001;
      end

      // ------------------------------------------------------------
      // drives, one colour only
      // ------------------------------------------------------------
      case (state_ff.status)
         LED_GREEN: begin
            nxt_state.red      = 1'b0;
            nxt_state.yellow   = 1'b0;
            nxt_state.green_on = 1'b1;
         end
         LED_YELLOW: begin
            nxt_state.red      = 1'b0;
            nxt_state.yellow   = 1'b1;
            nxt_state.green_on = 1'b0;
         end
         LED_RED: begin
            nxt_state.red      = 1'b1;
            nxt_state.yellow   = 1'b0;
            nxt_state.green_on = 1'b0;
         end
         LED_RED_BLINK: begin
            nxt_state.red      = state_ff.blink;
            nxt_state.yellow   = 1'b0;
            nxt_state.green_on = 1'b0;
         end
         default: begin
            nxt_state.red      = 1'b0;
            nxt_state.yellow   = 1'b0;
            nxt_state.green_on = 1'b0;
         end
      endcase
      nxt_state.green_duty = clamp_duty(state_ff.green_bright);

      // ------------------------------------------------------------
      // ambient light
      // ------------------------------------------------------------
      nxt_state.light_lux   = MEAS_I.lux;
      nxt_state.light_class = light_code(state_ff.light_lux,
                                         state_ff.standby_thr,
                                         state_ff.active_thr);

      // ------------------------------------------------------------
      // termination
      // ------------------------------------------------------------
      nxt_state.term_out = state_ff.bus_term[TERM_EN_BIT];

      // ------------------------------------------------------------
      // register access
      // ------------------------------------------------------------
      nxt_state.rsp = '0;
      if (REG_REQ_I.wr) begin
         nxt_state.rsp.ack = 1'b1;
         if (REG_REQ_I.input_space ||
             !holding_addr_ok(REG_REQ_I.addr)) begin
            nxt_state.rsp.err = 1'b1;
         end else begin
            case (REG_REQ_I.addr)
               ADDR_BUS_TERM: begin
                  nxt_state.bus_term = REG_REQ_I.wdata;
               end
               ADDR_ACTIVE_THR: begin
                  nxt_state.active_thr = REG_REQ_I.wdata;
               end
               ADDR_STANDBY_THR: begin
                  nxt_state.standby_thr = REG_REQ_I.wdata;
               end
               ADDR_SRC_SELECT: begin
                  nxt_state.src_select = REG_REQ_I.wdata;
               end
               ADDR_GREEN_BRIGHT: begin
                  nxt_state.green_bright = REG_REQ_I.wdata;
               end
               default: begin
                  nxt_state.rsp.err = 1'b1;
               end
            endcase
         end
      end else if (REG_REQ_I.rd) begin
         nxt_state.rsp.ack = 1'b1;
         if (REG_REQ_I.input_space) begin
            case (REG_REQ_I.addr)
               ADDR_LIGHT_LUX: begin
                  rd_value = state_ff.light_lux;
                  rd_hit   = 1'b1;
               end
               ADDR_LIGHT_CLASS: begin
                  rd_value = state_ff.light_class;
                  rd_hit   = 1'b1;
               end
               default: begin
                  rd_hit = 1'b0;
               end
            endcase
         end else begin
            rd_hit = 1'b1;
            case (REG_REQ_I.addr)
               ADDR_BUS_TERM: begin
                  rd_value = state_ff.bus_term;
               end
               ADDR_ACTIVE_THR: begin
                  rd_value = state_ff.active_thr;
               end
               ADDR_STANDBY_THR: begin
                  rd_value = state_ff.standby_thr;
               end
               ADDR_SRC_SELECT: begin
                  rd_value = state_ff.src_select;
               end
               ADDR_GREEN_BRIGHT: begin
                  rd_value = state_ff.green_bright;
               end
               default: begin
                  rd_hit = 1'b0;
               end
            endcase
         end
         nxt_state.rsp.err   = !rd_hit;
         nxt_state.rsp.rdata = rd_value;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_ff              <= '0;
         state_ff.active_thr   <= RST_ACTIVE_THR;
         state_ff.standby_thr  <= RST_STANDBY_THR;
         state_ff.bus_term     <= RST_BUS_TERM;
         state_ff.src_select   <= RST_SRC_SELECT;
         state_ff.green_bright <= RST_GREEN_BRIGHT;
         state_ff.light_class  <= CLASS_STANDBY;
         state_ff.status       <= LED_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ---------------------------------------------------------------
   // green brightness modulator
   // ---------------------------------------------------------------
   // next enable, so green drops on the edge red or yellow rises
   indicator_pwm u_green_pwm (
      .clk_i    (SYS_CLK_I),
      .rst_n_i  (RESET_N_I),
      .enable_i (nxt_state.green_on),
      .duty_i   (state_ff.green_duty),
      .pwm_o    (LED_GREEN_O)
   );

   assign LED_RED_O     = state_ff.red;
   assign LED_YELLOW_O  = state_ff.yellow;
   assign BUS_TERM_EN_O = state_ff.term_out;
   assign REG_RSP_O     = state_ff.rsp;

endmodule // status_led_and_light_classifier

/* File: sim/status_bus_master.sv */
// register master model facing the status block
`timescale 1ns/100ps
module status_bus_master
   import status_pkg::*;
(
   input  wire logic                 clk_i,  // system clock
   output status_pkg::reg_req_s      req_o,  // request to device
   input  wire status_pkg::reg_rsp_s rsp_i   // answer from device
);
   import status_pkg::*;
   initial req_o = '0;
   // one word access; answer taken 1 ns after the edge that samples the request
   task automatic xfer(input logic w, sp, input logic [15:0] a, d,
                       output reg_rsp_s r);
      req_o = '{w, !w, sp, a, d};
      @(posedge clk_i);
      #1;
      r = rsp_i;
      req_o = '{1'b0, 1'b0, !sp, ~a, ~d};
      @(posedge clk_i);
      #1;
   endtask
endmodule // status_bus_master

/* File: sim/status_led_sva.sv */
// port assertions of the status and light block
`timescale 1ns/100ps
module status_led_sva
   import status_pkg::*;
#(
   parameter int unsigned BLINK_HALF_CYCLES = status_pkg::BLINK_HALF_CYC
)
(
   input wire logic                 SYS_CLK_I,     // clock
   input wire logic                 RESET_N_I,     // reset, low
   input wire status_pkg::meas_s    MEAS_I,        // measurements
   input wire status_pkg::range_s   TEMP_RANGE_I,  // temp bounds
   input wire status_pkg::range_s   HUM_RANGE_I,   // hum bounds
   input wire status_pkg::reg_req_s REG_REQ_I,     // request
   input wire status_pkg::reg_rsp_s REG_RSP_O,     // answer
   input wire logic                 LED_GREEN_O,   // green
   input wire logic                 LED_YELLOW_O,  // yellow
   input wire logic                 LED_RED_O,     // red
   input wire logic                 BUS_TERM_EN_O  // terminator
);
   import status_pkg::*;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   function automatic logic [1:0] cls(logic signed [15:0] v, range_s g);
      if (v < g.meas_min || v > g.meas_max) return 2'h3;
      if (v < g.alert_min || v > g.alert_max) return 2'h2;
      return 2'h1;
   endfunction
   wire logic [1:0] tc = cls(MEAS_I.temp, TEMP_RANGE_I);
   wire logic [1:0] hc = cls(MEAS_I.hum, HUM_RANGE_I);
   wire logic       ok = MEAS_I.link_ok;
   wire logic       rq = REG_REQ_I.wr | REG_REQ_I.rd;
   int unsigned lost_ff, still_ff;
   logic        red_q_ff;
   // cycles of lost link and cycles since red last changed
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         lost_ff  <= 0;
         still_ff <= 0;
         red_q_ff <= 1'b0;
      end else begin
         lost_ff  <= ok ? 0 : lost_ff + 1;
         still_ff <= (LED_RED_O != red_q_ff) ? 0 : still_ff + 1;
         red_q_ff <= LED_RED_O;
      end
   end
   a_req_ack: assert property (rq |=> REG_RSP_O.ack)
      else $error("request without answer");
   a_idle_quiet: assert property (!rq |=> !REG_RSP_O.ack)
      else $error("answer without request");
   a_refuse_input: assert property (
      REG_REQ_I.wr && REG_REQ_I.input_space
      |=> REG_RSP_O.err && REG_RSP_O.rdata == 16'h0)
      else $error("input space write not refused");
   a_one_colour: assert property (
      $onehot0({LED_RED_O, LED_YELLOW_O, LED_GREEN_O}))
      else $error("more than one colour lit");
   a_red_steady: assert property (
      (ok && tc == 2'h3 && hc == 2'h3)[*3] |-> LED_RED_O)
      else $error("red missing outside range");
   a_yellow_alert: assert property (
      (ok && tc == 2'h2 && hc == 2'h2)[*3] |-> LED_YELLOW_O && !LED_RED_O)
      else $error("yellow missing in alert zone");
   a_green_calm: assert property (
      (ok && tc == 2'h1 && hc == 2'h1)[*3] |-> !LED_RED_O && !LED_YELLOW_O)
      else $error("warning colour inside alert bounds");
   a_lost_dark: assert property (
      (!ok)[*4] |-> !LED_YELLOW_O && !LED_GREEN_O)
      else $error("yellow or green lit with link lost");
   a_red_blinks: assert property (
      lost_ff > 2 * BLINK_HALF_CYCLES |-> still_ff < BLINK_HALF_CYCLES)
      else $error("red not blinking with link lost");
   a_term_follow: assert property (
      REG_REQ_I.wr && !REG_REQ_I.input_space
      && REG_REQ_I.addr == ADDR_BUS_TERM
      |-> ##2 BUS_TERM_EN_O == $past(REG_REQ_I.wdata[TERM_EN_BIT], 2))
      else $error("terminator does not follow write");
endmodule // status_led_sva
bind status_led_and_light_classifier status_led_sva #(
   .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) u_status_led_sva (
   .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .MEAS_I(MEAS_I),
   .TEMP_RANGE_I(TEMP_RANGE_I), .HUM_RANGE_I(HUM_RANGE_I),
   .REG_REQ_I(REG_REQ_I), .REG_RSP_O(REG_RSP_O),
   .LED_GREEN_O(LED_GREEN_O), .LED_YELLOW_O(LED_YELLOW_O),
   .LED_RED_O(LED_RED_O), .BUS_TERM_EN_O(BUS_TERM_EN_O));

/* File: sim/test_status_led_and_light_classifier.sv */
// self-checking bench of the status and light block
`timescale 1ns/100ps
module test_status_led_and_light_classifier;
   import status_pkg::*;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   meas_s       ms;
   range_s      tr = '{-16'sd100, 16'sd0, 16'sd400, 16'sd500};
   range_s      hr = '{16'sd0, 16'sd300, 16'sd700, 16'sd1000};
   reg_req_s    req;
   reg_rsp_s    rsp, r;
   logic        grn, yel, red, term;
   logic [15:0] stb, act, bright [3] = '{16'h0, 16'h3, 16'hc};
   logic [15:0] hm [logic [15:0]];
   int          fail_count = 0;
   int          check_count = 0;
   int          n;
   always #5 sys_clk = ~sys_clk;
   status_bus_master u_status_bus_master (
      .clk_i(sys_clk), .req_o(req), .rsp_i(rsp));
   status_led_and_light_classifier #(.BLINK_HALF_CYCLES(8))
      u_status_led_and_light_classifier (
      .SYS_CLK_I(sys_clk), .RESET_N_I(reset_n), .MEAS_I(ms),
      .TEMP_RANGE_I(tr), .HUM_RANGE_I(hr), .REG_REQ_I(req),
      .REG_RSP_O(rsp), .LED_GREEN_O(grn), .LED_YELLOW_O(yel),
      .LED_RED_O(red), .BUS_TERM_EN_O(term));
   task automatic chk(string nm, logic [15:0] s, e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic acc(logic w, sp, logic [15:0] a, d);
      u_status_bus_master.xfer(w, sp, a, d, r);
      chk("ack", 16'(r.ack), 16'h1);
      if (w && !sp && hm.exists(a)) hm[a] = d;
   endtask
   task automatic rchk(logic sp, logic [15:0] a, e);
      acc(1'b0, sp, a, 16'h0);
      chk("rdata", r.rdata, e);
   endtask
   // colour model: 1 green, 2 yellow, 4 red
   function automatic int col(logic signed [15:0] v, range_s g);
      if (v < g.meas_min || v > g.meas_max) return 4;
      if (v < g.alert_min || v > g.alert_max) return 2;
      return 1;
   endfunction
   task automatic led_chk();
      logic hs;
      hs = hm[ADDR_SRC_SELECT][SRC_SEL_BIT];
      chk("led", {13'h0, red, yel, grn},
          16'(col(hs ? ms.hum : ms.temp, hs ? hr : tr)));
   endtask
   // holding model back to reset values
   task automatic model_reset();
      hm[ADDR_BUS_TERM]     = RST_BUS_TERM;
      hm[ADDR_ACTIVE_THR]   = RST_ACTIVE_THR;
      hm[ADDR_STANDBY_THR]  = RST_STANDBY_THR;
      hm[ADDR_SRC_SELECT]   = RST_SRC_SELECT;
      hm[ADDR_GREEN_BRIGHT] = RST_GREEN_BRIGHT;
   endtask
   initial begin
      cyc(60000);
      fail_count++;
      complete_run();
   end
   initial begin
      ms = '{16'sd450, 16'sd500, 16'h0, 1'b1};
      model_reset();
      void'($urandom(32'hf6c6));
      cyc(8);
      reset_n = 1'b1;
      cyc(4);
      led_chk();
      foreach (hm[a]) rchk(1'b0, a, hm[a]);
      rchk(1'b0, 16'h0000, 16'h0);
      chk("err", 16'(r.err), 16'h1);
      acc(1'b1, 1'b1, ADDR_LIGHT_LUX, 16'h1234);
      chk("err", 16'(r.err), 16'h1);
      rchk(1'b1, ADDR_SRC_SELECT, 16'h0);
      chk("err", 16'(r.err), 16'h1);
      acc(1'b1, 1'b0, ADDR_LIGHT_LUX, 16'hffff);
      chk("err", 16'(r.err), 16'h1);
      foreach (hm[a]) acc(1'b1, 1'b0, a, 16'($urandom));
      foreach (hm[a]) rchk(1'b0, a, hm[a]);
      for (int i = 0; i < 2; i++) begin
         acc(1'b1, 1'b0, ADDR_BUS_TERM, 16'(i));
         cyc(1);
         chk("term", 16'(term), 16'(i));
      end
      acc(1'b1, 1'b0, ADDR_GREEN_BRIGHT, 16'ha);
      for (int i = 0; i < 40; i++) begin
         acc(1'b1, 1'b0, ADDR_SRC_SELECT, 16'($urandom_range(1)));
         ms.temp = ($urandom_range(3) == 0) ? tr[16*$urandom_range(3)+:16]
                                            : 16'($urandom_range(800) - 200);
         ms.hum  = ($urandom_range(3) == 0) ? hr[16*$urandom_range(3)+:16]
                                            : 16'($urandom_range(1200) - 100);
         cyc(4);
         led_chk();
      end
      // mid-run reset: source falls back to temperature
      reset_n = 1'b0;
      cyc(2);
      reset_n = 1'b1;
      model_reset();
      cyc(4);
      led_chk();
      chk("term", 16'(term), 16'(RST_BUS_TERM[TERM_EN_BIT]));
      rchk(1'b0, ADDR_SRC_SELECT, RST_SRC_SELECT);
      for (int i = 0; i < 24; i++) begin
         stb = 16'($urandom_range(600));
         act = stb + 16'($urandom_range(600));
         acc(1'b1, 1'b0, ADDR_STANDBY_THR, stb);
         acc(1'b1, 1'b0, ADDR_ACTIVE_THR, act);
         case (i % 3)
            0: ms.lux = stb;
            1: ms.lux = act;
            default: ms.lux = 16'($urandom_range(1300));
         endcase
         cyc(3);
         rchk(1'b1, ADDR_LIGHT_LUX, ms.lux);
         rchk(1'b1, ADDR_LIGHT_CLASS, ms.lux < stb ? CLASS_STANDBY
              : ms.lux > act ? CLASS_ACTIVE : CLASS_LOW);
      end
      ms.temp = 16'sd200;
      ms.hum  = 16'sd500;
      foreach (bright[k]) begin
         acc(1'b1, 1'b0, ADDR_GREEN_BRIGHT, bright[k]);
         cyc(4);
         n = 0;
         repeat (10000) begin
            cyc(1);
            n += grn;
         end
         chk("green", 16'(n), bright[k] > 10 ? 16'd10000
             : 16'(bright[k] * 1000));
      end
      ms.link_ok = 1'b0;
      cyc(3);
      n = 0;
      repeat (40) begin
         cyc(1);
         n += red;
         chk("dark", {14'h0, yel, grn}, 16'h0);
      end
      chk("blink", 16'(n >= 16 && n <= 24), 16'h1);
      ms.link_ok = 1'b1;
      cyc(4);
      complete_run();
   end
endmodule // test_status_led_and_light_classifier
